/* File: logic/iso_uframe_pkg.sv */
// Shared constants, register map and state types of the isochronous microframe engine.
package iso_uframe_pkg;

    // Geometry of the descriptor and of the per-microframe fields.
    localparam int DATA_W     = 32;
    localparam int ADDR_W     = 6;
    localparam int DESC_WORDS = 8;
    localparam int UFRAMES    = 8;
    localparam int COUNT_W    = 12;
    localparam int RESULT_W   = 3;
    localparam int FRAME_W    = 5;
    localparam int TOKEN_W    = 2;
    localparam int EVENT_W    = 4;

    // Byte addresses on the register bus.
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 6'h20;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = 6'h24;

    // Descriptor word indices, each word at byte address four times its index.
    localparam int TOKEN_WORD  = 1;
    localparam int FRAME_WORD  = 2;
    localparam int CTRL_WORD   = 3;
    localparam int STATUS_WORD = 4;
    localparam int COUNT_WORD  = 5;

    // Field positions inside their words.
    localparam int TOKEN_LSB  = 10;
    localparam int FRAME_LSB  = 3;
    localparam int VALID_BIT  = 31;
    localparam int HALT_BIT   = 30;
    localparam int MASK_LSB   = 0;
    localparam int RESULT_LSB = 8;

    // Bits of a 3-bit microframe result.
    localparam int RES_XERR     = 0;
    localparam int RES_BABBLE   = 1;
    localparam int RES_UNDERRUN = 2;

    // Token code that marks an IN endpoint.
    localparam logic [TOKEN_W-1:0] TOKEN_IN = 2'h1;

    // Interrupt event bits.
    localparam int EV_DONE  = 0;
    localparam int EV_ERROR = 1;
    localparam int EV_HALT  = 2;
    localparam int EV_EMPTY = 3;

    localparam logic [DATA_W-1:0]  WORD_RESET  = 32'h00000000;
    localparam logic [EVENT_W-1:0] EVENT_RESET = 4'h0;

    typedef enum {PH_IDLE, PH_ISSUE, PH_WAIT, PH_WRITE} phase_t;

endpackage

/* File: logic/irq_event_bank.sv */
// Sticky event bits with write-one-to-clear, a mask and one level interrupt.
`timescale 1ns/100ps
module irq_event_bank #(
    parameter int WIDTH = 4
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] event_set,
    input  wire logic [WIDTH-1:0] status_clear,
    input  wire logic             mask_write,
    input  wire logic [WIDTH-1:0] mask_data,
    output logic      [WIDTH-1:0] status,
    output logic      [WIDTH-1:0] mask,
    output logic                  irq
);

    typedef struct packed {
        logic [WIDTH-1:0] status;
        logic [WIDTH-1:0] mask;
    } bank_t;

    bank_t s;
    bank_t next_s;

    initial
    begin
        if (WIDTH < 1 || WIDTH > 32)
            $error("irq_event_bank: WIDTH must lie between 1 and 32.");
    end

    // A new event in the clearing cycle survives, so no event is lost.
    always_comb
    begin
        next_s = s;
        next_s.status = (s.status & ~status_clear) | event_set;
        if (mask_write)
            next_s.mask = mask_data;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign status = s.status;
    assign mask   = s.mask;
    assign irq    = |(s.status & s.mask);

endmodule

/* File: logic/iso_uframe_engine.sv */
// Isochronous microframe scheduler and result write-back for one transfer descriptor.
`timescale 1ns/100ps
module iso_uframe_engine #(
    parameter int FRAME_NUM_W = 11
) (
    input  wire logic                                    clock,
    input  wire logic                                    reset_n,
    input  wire logic [iso_uframe_pkg::ADDR_W-1:0]       address,
    input  wire logic                                    read,
    input  wire logic                                    write,
    input  wire logic [iso_uframe_pkg::DATA_W-1:0]       writedata,
    input  wire logic [3:0]                              byteenable,
    output logic      [iso_uframe_pkg::DATA_W-1:0]       readdata,
    output logic                                         waitrequest,
    output logic                                         irq,
    input  wire logic [FRAME_NUM_W-1:0]                  bus_frame_number,
    input  wire logic [2:0]                              bus_uframe,
    input  wire logic                                    uframe_start,
    output logic                                         xact_start,
    output logic      [2:0]                              xact_uframe,
    output logic                                         xact_in,
    input  wire logic                                    xact_done,
    input  wire logic [iso_uframe_pkg::COUNT_W-1:0]      xact_rx_count,
    input  wire logic                                    xact_error,
    input  wire logic                                    xact_babble,
    input  wire logic                                    xact_underrun,
    input  wire logic                                    xact_stall
);

    localparam int REGION_W = 3 * iso_uframe_pkg::DATA_W;

    typedef struct packed {
        iso_uframe_pkg::phase_t                                                    phase;
        logic [iso_uframe_pkg::DESC_WORDS-1:0][iso_uframe_pkg::DATA_W-1:0]         desc;
        logic [2:0]                                                                uf;
        logic [iso_uframe_pkg::COUNT_W-1:0]                                        cnt;
        logic [iso_uframe_pkg::RESULT_W-1:0]                                       res;
        logic                                                                      stall;
        logic                                                                      is_in;
        logic                                                                      ack;
        logic [iso_uframe_pkg::DATA_W-1:0]                                         rdata;
    } engine_t;

    engine_t                                   s;
    engine_t                                   next_s;
    logic [REGION_W-1:0]                       region;
    logic [iso_uframe_pkg::DATA_W-1:0]         merged;
    logic [iso_uframe_pkg::EVENT_W-1:0]        ev_set;
    logic [iso_uframe_pkg::EVENT_W-1:0]        ev_clear;
    logic [iso_uframe_pkg::EVENT_W-1:0]        ev_status;
    logic [iso_uframe_pkg::EVENT_W-1:0]        ev_mask;
    logic                                      mask_write;
    logic                                      frame_hit;
    logic [iso_uframe_pkg::UFRAMES-1:0]        active_mask;
    logic                                      desc_hit;
    logic [2:0]                                word_sel;
    logic                                      valid;

    initial
    begin
        if (FRAME_NUM_W < iso_uframe_pkg::FRAME_W)
            $error("iso_uframe_engine: FRAME_NUM_W is narrower than the frame field.");
    end

    // Bit position of microframe k's count inside the words 5..7 region.
    function automatic int count_lsb(input logic [2:0] k);
        count_lsb = int'(k) * iso_uframe_pkg::COUNT_W;
    endfunction

    // Bit position of microframe k's result inside word 4.
    function automatic int result_lsb(input logic [2:0] k);
        result_lsb = iso_uframe_pkg::RESULT_LSB + int'(k) * iso_uframe_pkg::RESULT_W;
    endfunction

    // Counts are laid out back to back over words 5..7, which yields the split fields.
    function automatic logic [iso_uframe_pkg::COUNT_W-1:0] count_of(
        input logic [iso_uframe_pkg::DESC_WORDS-1:0][iso_uframe_pkg::DATA_W-1:0] d,
        input logic [2:0] k);
        logic [REGION_W-1:0] r;
        r = {d[iso_uframe_pkg::COUNT_WORD+2], d[iso_uframe_pkg::COUNT_WORD+1],
             d[iso_uframe_pkg::COUNT_WORD]};
        count_of = r[count_lsb(k) +: iso_uframe_pkg::COUNT_W];
    endfunction

    function automatic logic [iso_uframe_pkg::RESULT_W-1:0] result_of(
        input logic [iso_uframe_pkg::DESC_WORDS-1:0][iso_uframe_pkg::DATA_W-1:0] d,
        input logic [2:0] k);
        result_of = d[iso_uframe_pkg::STATUS_WORD][result_lsb(k) +: iso_uframe_pkg::RESULT_W];
    endfunction

    assign active_mask = s.desc[iso_uframe_pkg::STATUS_WORD]
                               [iso_uframe_pkg::MASK_LSB +: iso_uframe_pkg::UFRAMES];
    assign valid       = s.desc[iso_uframe_pkg::CTRL_WORD][iso_uframe_pkg::VALID_BIT];

    // Only bits 7..3 of the frame byte take part; bits 2..0 are don't-care.
    assign frame_hit = s.desc[iso_uframe_pkg::FRAME_WORD]
                             [iso_uframe_pkg::FRAME_LSB +: iso_uframe_pkg::FRAME_W]
                       == bus_frame_number[iso_uframe_pkg::FRAME_W-1:0];

    assign desc_hit = (address[iso_uframe_pkg::ADDR_W-1] == 1'b0);
    assign word_sel = address[4:2];

    always_comb
    begin
        region = '0;
        merged = '0;
        next_s = s;
        unique case (s.phase)
            iso_uframe_pkg::PH_IDLE:
            begin
                // Each microframe start tests only the bit picked by the bus microframe,
                // so an all-ones mask runs all eight and 8'h55 runs the even ones.
                if (uframe_start && valid && frame_hit
                    && active_mask[bus_uframe])
                begin
                    next_s.phase = iso_uframe_pkg::PH_ISSUE;
                    next_s.uf    = bus_uframe;
                    next_s.is_in = s.desc[iso_uframe_pkg::TOKEN_WORD]
                                         [iso_uframe_pkg::TOKEN_LSB +: iso_uframe_pkg::TOKEN_W]
                                   == iso_uframe_pkg::TOKEN_IN;
                end
            end
            iso_uframe_pkg::PH_ISSUE:
            begin
                next_s.phase = iso_uframe_pkg::PH_WAIT;
            end
            iso_uframe_pkg::PH_WAIT:
            begin
                // Nothing is written back until the link says the payload is over.
                if (xact_done)
                begin
                    next_s.phase = iso_uframe_pkg::PH_WRITE;
                    next_s.cnt   = xact_rx_count;
                    next_s.stall = xact_stall;
                    next_s.res   = '0;
                    next_s.res[iso_uframe_pkg::RES_XERR]     = xact_error;
                    next_s.res[iso_uframe_pkg::RES_BABBLE]   = xact_babble & s.is_in;
                    next_s.res[iso_uframe_pkg::RES_UNDERRUN] = xact_underrun & ~s.is_in;
                end
            end
            iso_uframe_pkg::PH_WRITE:
            begin
                next_s.phase = iso_uframe_pkg::PH_IDLE;
                next_s.desc[iso_uframe_pkg::STATUS_WORD]
                      [result_lsb(s.uf) +: iso_uframe_pkg::RESULT_W] = s.res;
                next_s.desc[iso_uframe_pkg::STATUS_WORD]
                      [iso_uframe_pkg::MASK_LSB + int'(s.uf)] = 1'b0;
                // Counts are received bytes, so OUT microframes leave their field alone.
                if (s.is_in)
                begin
                    region = {s.desc[iso_uframe_pkg::COUNT_WORD+2],
                              s.desc[iso_uframe_pkg::COUNT_WORD+1],
                              s.desc[iso_uframe_pkg::COUNT_WORD]};
                    region[count_lsb(s.uf) +: iso_uframe_pkg::COUNT_W] = s.cnt;
                    {next_s.desc[iso_uframe_pkg::COUNT_WORD+2],
                     next_s.desc[iso_uframe_pkg::COUNT_WORD+1],
                     next_s.desc[iso_uframe_pkg::COUNT_WORD]} = region;
                end
                if (s.stall)
                begin
                    next_s.desc[iso_uframe_pkg::CTRL_WORD][iso_uframe_pkg::HALT_BIT]  = 1'b1;
                    next_s.desc[iso_uframe_pkg::CTRL_WORD]
                          [iso_uframe_pkg::VALID_BIT] = 1'b0;
                end
            end
        endcase

        // The bus is held off across write-back, so software and engine never
        // update the descriptor in the same cycle.
        next_s.ack = (read || write) && !s.ack && (next_s.phase != iso_uframe_pkg::PH_WRITE);

        if (next_s.ack && read)
        begin
            if (desc_hit)
                next_s.rdata = s.desc[word_sel];
            else if (address == iso_uframe_pkg::IRQ_STATUS_ADDR)
                next_s.rdata = {{(iso_uframe_pkg::DATA_W-iso_uframe_pkg::EVENT_W){1'b0}},
                                ev_status};
            else if (address == iso_uframe_pkg::IRQ_MASK_ADDR)
                next_s.rdata = {{(iso_uframe_pkg::DATA_W-iso_uframe_pkg::EVENT_W){1'b0}}, ev_mask};
            else
                next_s.rdata = iso_uframe_pkg::WORD_RESET;
        end

        if (s.ack && write && desc_hit)
        begin
            merged = s.desc[word_sel];
            for (int b = 0; b < 4; b++)
            begin
                if (byteenable[b])
                    merged[8*b +: 8] = writedata[8*b +: 8];
            end
            // Mask bits only move from zero to one under software.
            if (int'(word_sel) == iso_uframe_pkg::STATUS_WORD)
                merged[iso_uframe_pkg::MASK_LSB +: iso_uframe_pkg::UFRAMES] =
                    active_mask | (merged[iso_uframe_pkg::MASK_LSB +: iso_uframe_pkg::UFRAMES]);
            next_s.desc[word_sel] = merged;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            s       <= '0;
            s.phase <= iso_uframe_pkg::PH_IDLE;
        end
        else
            s <= next_s;
    end

    // Events are raised in the write-back cycle.
    always_comb
    begin
        ev_set = iso_uframe_pkg::EVENT_RESET;
        if (s.phase == iso_uframe_pkg::PH_WRITE)
        begin
            ev_set[iso_uframe_pkg::EV_DONE]  = 1'b1;
            ev_set[iso_uframe_pkg::EV_ERROR] = |s.res;
            ev_set[iso_uframe_pkg::EV_HALT]  = s.stall;
            ev_set[iso_uframe_pkg::EV_EMPTY] = (next_s.desc[iso_uframe_pkg::STATUS_WORD]
                [iso_uframe_pkg::MASK_LSB +: iso_uframe_pkg::UFRAMES] == '0);
        end
    end

    assign ev_clear   = (s.ack && write && address == iso_uframe_pkg::IRQ_STATUS_ADDR)
                        ? writedata[iso_uframe_pkg::EVENT_W-1:0] : iso_uframe_pkg::EVENT_RESET;
    assign mask_write = s.ack && write && (address == iso_uframe_pkg::IRQ_MASK_ADDR);

    irq_event_bank #(
        .WIDTH (iso_uframe_pkg::EVENT_W)
    ) events (
        .clock        (clock),
        .reset_n      (reset_n),
        .event_set    (ev_set),
        .status_clear (ev_clear),
        .mask_write   (mask_write),
        .mask_data    (writedata[iso_uframe_pkg::EVENT_W-1:0]),
        .status       (ev_status),
        .mask         (ev_mask),
        .irq          (irq)
    );

    assign readdata    = s.rdata;
    assign waitrequest = (read || write) && !s.ack;
    assign xact_start  = (s.phase == iso_uframe_pkg::PH_ISSUE);
    assign xact_uframe = s.uf;
    assign xact_in     = s.is_in;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    AST_FRAME_GATE: assert property (
        (s.phase == iso_uframe_pkg::PH_IDLE && uframe_start && !frame_hit)
        |=> s.phase == iso_uframe_pkg::PH_IDLE)
        else $error("Microframe serviced in a frame that does not match.");

    AST_MASK_GATE: assert property (
        (s.phase == iso_uframe_pkg::PH_IDLE && uframe_start && !active_mask[bus_uframe])
        |=> !xact_start)
        else $error("Microframe serviced with its mask bit clear.");

    AST_SELECT_UF: assert property (
        $rose(xact_start) |-> xact_uframe == $past(bus_uframe))
        else $error("Serviced microframe differs from the bus microframe.");

    AST_CLEAR_MASK: assert property (
        s.phase == iso_uframe_pkg::PH_WRITE
        |=> !active_mask[$past(s.uf)] && s.phase == iso_uframe_pkg::PH_IDLE)
        else $error("Mask bit of a serviced microframe not cleared.");

    AST_SOFT_SET_ONLY: assert property (
        (s.ack && write && desc_hit && int'(word_sel) == iso_uframe_pkg::STATUS_WORD)
        |=> ($past(active_mask) & ~active_mask) == '0)
        else $error("Software write cleared a mask bit.");

    AST_RESULT_AFTER_DONE: assert property (
        (s.phase == iso_uframe_pkg::PH_WAIT && !xact_done)
        |=> s.phase == iso_uframe_pkg::PH_WAIT)
        else $error("Write-back started before the payload finished.");

    AST_RESULT_FIELD: assert property (
        (s.phase == iso_uframe_pkg::PH_WAIT && xact_done)
        |=> ##1 result_of(s.desc, $past(s.uf, 2)) ==
            {$past(xact_underrun, 2) & !$past(s.is_in, 2),
             $past(xact_babble, 2) & $past(s.is_in, 2), $past(xact_error, 2)})
        else $error("Result field does not hold the reported outcome.");

    AST_DIR_BITS: assert property (
        (s.phase == iso_uframe_pkg::PH_WRITE)
        |-> !(s.is_in && s.res[iso_uframe_pkg::RES_UNDERRUN])
            && !(!s.is_in && s.res[iso_uframe_pkg::RES_BABBLE]))
        else $error("Result bit used for the wrong direction.");

    AST_COUNT_PLACE: assert property (
        (s.phase == iso_uframe_pkg::PH_WRITE && s.is_in)
        |=> count_of(s.desc, $past(s.uf)) == $past(s.cnt))
        else $error("Received count not in the microframe's field.");

    AST_HALT_VALID: assert property (
        (s.phase == iso_uframe_pkg::PH_WRITE && s.stall)
        |=> s.desc[iso_uframe_pkg::CTRL_WORD][iso_uframe_pkg::HALT_BIT] && !valid)
        else $error("Halt set without clearing valid.");

    // These tie the hand-off to the link and the mask bookkeeping together, so a stray
    // start or a second cleared bit shows up in the cycle where it happens.
    AST_START_PULSE: assert property (
        xact_start |=> !xact_start)
        else $error("Transaction request held longer than one cycle.");

    AST_START_CAUSE: assert property (
        xact_start |-> $past(uframe_start) && $past(frame_hit) && $past(valid))
        else $error("Transaction requested without a matching microframe start.");

    AST_ONE_BIT_CLEARED: assert property (
        s.phase == iso_uframe_pkg::PH_WRITE
        |=> $countones(active_mask) + 1 == $countones($past(active_mask)))
        else $error("Write-back cleared other than exactly one mask bit.");

    AST_OUT_COUNT_KEEP: assert property (
        (s.phase == iso_uframe_pkg::PH_WRITE && !s.is_in)
        |=> $stable(s.desc[iso_uframe_pkg::COUNT_WORD])
            && $stable(s.desc[iso_uframe_pkg::COUNT_WORD+1])
            && $stable(s.desc[iso_uframe_pkg::COUNT_WORD+2]))
        else $error("OUT microframe changed a received count.");

endmodule

/* File: test/iso_link_model.sv */
// Link partner that answers each isochronous transaction after a programmable delay.
`timescale 1ns/100ps
module iso_link_model (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        xact_start,
    input  wire logic [2:0]  xact_uframe,
    input  wire logic [7:0]  delay,
    input  wire logic [11:0] count_base,
    input  wire logic [3:0]  flags,
    output logic             xact_done,
    output logic      [11:0] xact_rx_count,
    output logic             xact_error,
    output logic             xact_babble,
    output logic             xact_underrun,
    output logic             xact_stall
);
    logic       busy;
    logic [7:0] left;
    logic [3:0] fl;
    assign {xact_stall, xact_underrun, xact_babble, xact_error} = fl;
    // Outside the done pulse the result lines toggle, so a stale value never looks valid.
    always_ff @(posedge clock)
    begin
        xact_done <= 1'b0;
        xact_rx_count <= ~xact_rx_count;
        fl <= ~fl;
        if (!reset_n)
        begin
            busy <= 1'b0;
            left <= 8'h00;
            fl <= 4'h0;
            xact_rx_count <= 12'h000;
        end
        else if (xact_start)
        begin
            busy <= 1'b1;
            left <= delay;
        end
        else if (busy && left == 8'h00)
        begin
            busy <= 1'b0;
            xact_done <= 1'b1;
            fl <= flags;
            xact_rx_count <= count_base + {9'h000, xact_uframe};
        end
        else if (busy)
        begin
            left <= left - 8'h01;
        end
    end
endmodule

/* File: test/iso_uframe_status_tb.sv */
// Self-checking bench of the isochronous microframe engine.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module iso_microframe_status_tb;
    typedef struct packed {logic [7:0] mask; logic in_tok; logic [3:0] fl; logic [11:0] base;
                           logic [2:0] res;} row_t;
    logic        clock = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, uframe_start = 1'b0;
    logic [5:0]  address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, scratch, exp4;
    logic [10:0] bus_frame_number = 11'h7E5;
    logic [2:0]  bus_uframe = 3'h0, xact_uframe;
    logic        waitrequest, irq, xact_start, xact_in, xact_done;
    logic        xact_error, xact_babble, xact_underrun, xact_stall;
    logic [11:0] xact_rx_count, count_base = 12'h000;
    logic [7:0]  delay = 8'h00;
    logic [3:0]  flags = 4'h0;
    logic [35:0] expc;
    int          n_mismatch = 0, n_compared = 0, cycles = 0;
    logic        wait_seen, start_seen, done_seen;
    logic [31:0] data_seen;
    row_t        rows [4] = '{'{8'hFF, 1'b1, 4'h6, 12'h123, 3'h2},
                              '{8'h55, 1'b0, 4'h7, 12'h0, 3'h5},
                              '{8'h07, 1'b1, 4'h1, 12'hFFD, 3'h1},
                              '{8'hAA, 1'b0, 4'h4, 12'h0, 3'h4}};

    iso_uframe_engine dut (.clock, .reset_n, .address, .read, .write, .writedata,
        .byteenable(4'hF), .readdata, .waitrequest, .irq, .bus_frame_number, .bus_uframe,
        .uframe_start, .xact_start, .xact_uframe, .xact_in, .xact_done, .xact_rx_count,
        .xact_error, .xact_babble, .xact_underrun, .xact_stall);
    iso_link_model link (.clock, .reset_n, .xact_start, .xact_uframe, .delay, .count_base,
        .flags, .xact_done, .xact_rx_count, .xact_error, .xact_babble, .xact_underrun, .xact_stall);

    always #2.5 clock = ~clock;

    // Outputs are taken at the falling edge, where they have settled, so no check races
    // the rising edge that moves them.
    always @(negedge clock)
    begin
        wait_seen  <= waitrequest;
        data_seen  <= readdata;
        start_seen <= xact_start;
        done_seen  <= xact_done;
    end

    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    // One bus cycle; an idle cycle follows so no strobe is reassigned in one time step.
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
        address <= a;
        writedata <= wd;
        write <= wr;
        read <= !wr;
        @(posedge clock);
        while (wait_seen !== 1'b0)
            @(posedge clock);
        rd = data_seen;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clock);
    endtask

    task wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, scratch);
    endtask

    task rd_chk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, scratch);
        `CHK(scratch, e)
    endtask

    task run_uframe(input logic [2:0] u, input logic go, input logic peek);
        bus_uframe <= u;
        uframe_start <= 1'b1;
        @(posedge clock);
        uframe_start <= 1'b0;
        @(posedge clock);
        `CHK(start_seen, go)
        if (start_seen === 1'b1)
        begin
            `CHK(xact_uframe, u)
            if (peek)
                rd_chk(6'h10, 32'h3);
            while (done_seen !== 1'b1)
                @(posedge clock);
            repeat (2) @(posedge clock);
        end
    endtask

    initial
    begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        `CHK(irq, 1'b0)
        rd_chk(6'h10, 32'h0);
        for (int r = 0; r < 4; r++)
        begin
            flags <= rows[r].fl;
            count_base <= rows[r].base;
            delay <= 8'(r * 3);
            wr(6'h04, {20'h0, rows[r].in_tok ? 2'h1 : 2'h0, 10'h0});
            wr(6'h08, 32'h2F); // Low three bits set on purpose, they must not matter.
            wr(6'h0C, 32'h8000_0000);
            wr(6'h14, 32'h0);
            wr(6'h18, 32'h0);
            wr(6'h10, {24'h0, rows[r].mask});
            exp4 = 32'h0;
            expc = 36'h0;
            for (int k = 0; k < 8; k++)
            begin
                run_uframe(3'(k), rows[r].mask[k], 1'b0);
                if (rows[r].mask[k])
                    `CHK(xact_in, rows[r].in_tok)
                if (rows[r].mask[k])
                    exp4[8 + 3 * k +: 3] = rows[r].res;
                if (rows[r].mask[k] && rows[r].in_tok && k < 3)
                    expc[12 * k +: 12] = rows[r].base + 12'(k);
            end
            rd_chk(6'h10, exp4);
            rd_chk(6'h14, expc[31:0]);
            bus(1'b0, 6'h18, 32'h0, scratch);
            `CHK(scratch[3:0], expc[35:32])
        end
        wr(6'h20, 32'hF);
        wr(6'h10, 32'h3);
        bus_frame_number <= 11'h7E6;
        run_uframe(3'h0, 1'b0, 1'b0);
        wr(6'h10, 32'h0);
        rd_chk(6'h10, 32'h3);
        bus_frame_number <= 11'h7E5;
        delay <= 8'h0A;
        flags <= 4'h8;
        run_uframe(3'h0, 1'b1, 1'b1);
        rd_chk(6'h0C, 32'h4000_0000);
        rd_chk(6'h10, 32'h2);
        rd_chk(6'h20, 32'h5);
        `CHK(irq, 1'b0)
        wr(6'h24, 32'h4);
        `CHK(irq, 1'b1)
        wr(6'h20, 32'h4);
        `CHK(irq, 1'b0)
        rd_chk(6'h20, 32'h1);
        wr(6'h28, 32'hFFFF_FFFF);
        rd_chk(6'h28, 32'h0);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd_chk(6'h24, 32'h0);
        rd_chk(6'h0C, 32'h0);
        wrap_up();
    end
endmodule
